// file: logic/tsag_defines.svh
// Operation
// - Reference-mode bit 11 clear selects ratiometric; set selects single-ended.
// - Single-ended X: drive both X plates, sample Y-high, internal reference.
// - Single-ended: panel drivers may switch off once acquisition ends.
// - Ratiometric Y: reference across Y plates, sample X-high.
// - Ratiometric: excitation stays on through acquisition and conversion.
// - Channel 1010b drives Y-high/X-low, samples Y-low, result at 11010b.
// - Channel 0010b drives Y-high/X-low, samples X-high, result at 10010b.
// - Never acquire while the halt input is active; registered adcTrack stays high until the next clock edge samples the halt.
// - Halt during acquisition aborts it; restart once halt goes inactive.
// - Polarity bit 3 of register 0x02: 1 active high, 0 active low.
// - Polarity bit resets to 0, halt input active low.
// - Halt input ignored during conversion and first-conversion delay.
// - Gating applies to every ADC channel.
`ifndef TSAG_DEFINES_SVH
`define TSAG_DEFINES_SVH
`define TSAG_ADDR_CTRL1 5'h01
`define TSAG_ADDR_CTRL2 5'h02
`define TSAG_RES_BASE_BIT 4
`define TSAG_REFMODE_BIT 11
`define TSAG_CHAN_LSB 7
`define TSAG_POL_BIT 3
`define TSAG_ACQ_LSB 0
`define TSAG_DLY_LSB 4
`define TSAG_CTRL1_RST 16'h0000
`define TSAG_CTRL2_RST 16'h0000
`define TSAG_CONV_CYCLES 8'h0E
`define TSAG_CH_X 4'h0
`define TSAG_CH_Y 4'h1
`define TSAG_CH_Z2 4'h2
`define TSAG_CH_Z1 4'hA
`define TSAG_DRV_X 4'hC
`define TSAG_DRV_Y 4'h3
`define TSAG_DRV_Z 4'h6
`define TSAG_DRV_OFF 4'h0
`endif

// file: logic/tsag_pkg.sv
package tsag_pkg;
  typedef enum logic [2:0] {
    TSAG_IDLE, TSAG_PWRUP, TSAG_ACQ, TSAG_CONV
  } tsag_phase_t;
  // Reference source for the ADC: internal, or across a plate pair
  typedef enum logic [1:0] {
    TSAG_REF_INT, TSAG_REF_X, TSAG_REF_Y, TSAG_REF_YX
  } tsag_ref_t;
endpackage : tsag_pkg

// file: logic/tsag_acq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tsag_acq_if;
  logic start;
  logic haltActive;
  logic [7:0] acqLen;
  logic done;
  logic halted;
  modport ctrl (output start, output haltActive, output acqLen,
                input done, input halted);
  modport gate (input start, input haltActive, input acqLen,
                output done, output halted);
endinterface : tsag_acq_if
`default_nettype wire

// file: logic/tsag_acq_gate.sv
`timescale 1ns/1ps
`default_nettype none
module tsag_acq_gate
  import tsag_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  tsag_acq_if.gate acq
);
  typedef struct packed {
    logic busy;
    logic [7:0] cnt;
  } tsag_gate_t;

  tsag_gate_t s, next_s;

  always_comb begin
    next_s = s;
    if (acq.start) begin
      next_s.busy = 1'b1;
      next_s.cnt = acq.acqLen;
    end else if (s.busy) begin
      if (acq.haltActive) begin
        // Abort and rearm the whole window; counting resumes on release
        next_s.cnt = acq.acqLen;
      end else if (s.cnt <= 8'h01) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.cnt = s.cnt - 8'h01;
      end
    end
  end

  // Halt only matters while busy, so delay and conversion are immune
  assign acq.done = s.busy && !acq.haltActive && (s.cnt <= 8'h01);
  assign acq.halted = s.busy && acq.haltActive;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  restart_full_a: assert property (
    s.busy && acq.haltActive && !acq.start
    |=> s.cnt == $past(acq.acqLen))
    else $error("acquisition window not rearmed after halt");
  abort_hold_a: assert property (
    s.busy && acq.haltActive |-> !acq.done ##1 s.busy)
    else $error("acquisition finished while halted");
  halt_cov_c: cover property (acq.halted ##1 !acq.haltActive ##[1:40] acq.done);
endmodule : tsag_acq_gate
`default_nettype wire

// file: logic/tsag_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsag_defines.svh"
module tsag_ctrl
  import tsag_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regWe,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  input wire logic convStart,
  input wire logic [11:0] adcResult,
  input wire logic acqHaltInput,
  output logic xPlusDrv,
  output logic xMinusDrv,
  output logic yPlusDrv,
  output logic yMinusDrv,
  output logic [3:0] adcMuxSel,
  output logic [1:0] adcRefSel,
  output logic adcTrack,
  output logic adcConvert,
  output logic convBusy,
  output logic resultReady
);
  typedef struct packed {
    tsag_phase_t phase;
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [7:0] cnt;
    logic [3:0] chan;
    logic [3:0] drive;
    tsag_ref_t refSel;
    logic track;
    logic convert;
    logic ready;
    logic busy;
    logic [15:0] rdata;
    logic [15:0][11:0] res;
  } tsag_regs_t;

  tsag_regs_t s, next_s;
  tsag_acq_if acq ();
  logic singleEnded;
  logic haltActive;

  // Plate drive pattern {X+, X-, Y+, Y-} for a channel code
  function automatic logic [3:0] tsagDrive(input logic [3:0] ch);
    case (ch)
      `TSAG_CH_X: tsagDrive = `TSAG_DRV_X;
      `TSAG_CH_Y: tsagDrive = `TSAG_DRV_Y;
      `TSAG_CH_Z1, `TSAG_CH_Z2: tsagDrive = `TSAG_DRV_Z;
      default: tsagDrive = `TSAG_DRV_OFF;
    endcase
  endfunction : tsagDrive

  // Reference routing; only panel channels can go ratiometric
  function automatic tsag_ref_t tsagRef(input logic [3:0] ch,
                                        input logic single);
    if (single) begin
      tsagRef = TSAG_REF_INT;
    end else begin
      case (ch)
        `TSAG_CH_X: tsagRef = TSAG_REF_X;
        `TSAG_CH_Y: tsagRef = TSAG_REF_Y;
        `TSAG_CH_Z1, `TSAG_CH_Z2: tsagRef = TSAG_REF_YX;
        default: tsagRef = TSAG_REF_INT;
      endcase
    end
  endfunction : tsagRef

  assign singleEnded = s.ctrl1[`TSAG_REFMODE_BIT];
  // Pin level equal to the polarity bit means halt
  assign haltActive = (acqHaltInput == s.ctrl2[`TSAG_POL_BIT]);
  assign acq.haltActive = haltActive;
  assign acq.acqLen = {5'h00, s.ctrl2[`TSAG_ACQ_LSB +: 3]} + 8'h01;
  assign acq.start = (s.phase == TSAG_PWRUP) && (s.cnt <= 8'h01);

  tsag_acq_gate u_gate (
    .clk(clk),
    .rst_n(rst_n),
    .acq(acq)
  );

  always_comb begin
    next_s = s;
    next_s.ready = 1'b0;
    if (regWe && regAddr == `TSAG_ADDR_CTRL1) begin
      next_s.ctrl1 = regWdata;
    end
    if (regWe && regAddr == `TSAG_ADDR_CTRL2) begin
      next_s.ctrl2 = regWdata;
    end
    case (s.phase)
      TSAG_IDLE: begin
        if (convStart) begin
          next_s.chan = s.ctrl1[`TSAG_CHAN_LSB +: 4];
          next_s.drive = tsagDrive(next_s.chan);
          next_s.refSel = tsagRef(next_s.chan, singleEnded);
          // Delay gives the panel and reference time to settle
          next_s.cnt = {2'b00, s.ctrl2[`TSAG_DLY_LSB +: 4], 2'b00};
          next_s.phase = TSAG_PWRUP;
        end
      end
      TSAG_PWRUP: begin
        if (s.cnt <= 8'h01) begin
          next_s.phase = TSAG_ACQ;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      TSAG_ACQ: begin
        // Every channel passes through the same gated window
        if (acq.done) begin
          next_s.phase = TSAG_CONV;
          next_s.cnt = `TSAG_CONV_CYCLES;
          next_s.convert = 1'b1;
          if (singleEnded) begin
            // Input is held; panel current would be wasted from here on, so drive goes off
            next_s.drive = `TSAG_DRV_OFF;
          end else begin
            // Panel is the reference, so drive stays through conversion
            next_s.drive = s.drive;
          end
        end
      end
      TSAG_CONV: begin
        if (s.cnt <= 8'h01) begin
          next_s.res[s.chan] = adcResult;
          next_s.ready = 1'b1;
          next_s.convert = 1'b0;
          next_s.drive = `TSAG_DRV_OFF;
          next_s.refSel = TSAG_REF_INT;
          next_s.phase = TSAG_IDLE;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      default: next_s.phase = TSAG_IDLE;
    endcase
    // Registered, so tracking lags the halt pin by one cycle
    next_s.track = (s.phase == TSAG_ACQ) && !haltActive && !acq.done;
    // Busy is registered so the pin never carries a decode glitch
    next_s.busy = (next_s.phase != TSAG_IDLE);
    if (regAddr == `TSAG_ADDR_CTRL1) begin
      next_s.rdata = s.ctrl1;
    end else if (regAddr == `TSAG_ADDR_CTRL2) begin
      next_s.rdata = s.ctrl2;
    end else if (regAddr[`TSAG_RES_BASE_BIT]) begin
      next_s.rdata = {4'h0, s.res[regAddr[3:0]]};
    end else begin
      next_s.rdata = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl1 <= `TSAG_CTRL1_RST;
      s.ctrl2 <= `TSAG_CTRL2_RST;
      s.phase <= TSAG_IDLE;
      s.refSel <= TSAG_REF_INT;
    end else begin
      s <= next_s;
    end
  end

  assign {xPlusDrv, xMinusDrv, yPlusDrv, yMinusDrv} = s.drive;
  assign adcMuxSel = s.chan;
  assign adcRefSel = s.refSel;
  assign adcTrack = s.track;
  assign adcConvert = s.convert;
  assign convBusy = s.busy;
  assign resultReady = s.ready;
  assign regRdata = s.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  no_track_halt_a: assert property (
    (acqHaltInput == s.ctrl2[`TSAG_POL_BIT]) |=> !adcTrack)
    else $error("tracking while halt input active");
  track_resume_a: assert property (
    s.phase == TSAG_ACQ && !haltActive && !acq.done |=> adcTrack)
    else $error("tracking did not resume after halt");
  halt_abort_a: assert property (
    acq.halted |=> !adcTrack)
    else $error("tracking continued through an aborted window");
  ratio_drive_a: assert property (
    adcConvert && !singleEnded |-> s.drive == tsagDrive(s.chan))
    else $error("excitation dropped in ratiometric conversion");
  single_off_a: assert property (
    adcConvert && singleEnded |-> s.drive == `TSAG_DRV_OFF)
    else $error("excitation left on in single-ended conversion");
  y_ratio_ref_a: assert property (
    convBusy && s.chan == `TSAG_CH_Y && !singleEnded
    |-> adcRefSel == TSAG_REF_Y)
    else $error("wrong reference for ratiometric Y");
  x_single_a: assert property (
    s.phase == TSAG_ACQ && s.chan == `TSAG_CH_X && singleEnded
    |-> s.drive == `TSAG_DRV_X && adcRefSel == TSAG_REF_INT)
    else $error("wrong routing for single-ended X");
  z_drive_a: assert property (
    s.phase == TSAG_ACQ
    && (s.chan == `TSAG_CH_Z1 || s.chan == `TSAG_CH_Z2)
    |-> s.drive == `TSAG_DRV_Z)
    else $error("wrong plate drive for pressure channel");
  z1_store_a: assert property (
    s.phase == TSAG_CONV && s.cnt <= 8'h01 && s.chan == `TSAG_CH_Z1
    |=> resultReady && s.res[`TSAG_CH_Z1] == $past(adcResult))
    else $error("pressure A result not stored");
  z2_store_a: assert property (
    s.phase == TSAG_CONV && s.cnt <= 8'h01 && s.chan == `TSAG_CH_Z2
    |=> s.res[`TSAG_CH_Z2] == $past(adcResult))
    else $error("pressure B result not stored");
  delay_immune_a: assert property (
    s.phase == TSAG_PWRUP && s.cnt > 8'h01
    |=> s.phase == TSAG_PWRUP && s.cnt == $past(s.cnt) - 8'h01)
    else $error("delay disturbed");
  conv_immune_a: assert property (
    s.phase == TSAG_CONV && s.cnt > 8'h01
    |=> s.phase == TSAG_CONV && adcConvert)
    else $error("conversion disturbed");
  track_phase_a: assert property (
    adcTrack |-> s.phase == TSAG_ACQ)
    else $error("tracking outside the acquisition window");
  conv_len_a: assert property (
    $rose(adcConvert) |-> adcConvert[*8] ##1 adcConvert[*6] ##1 !adcConvert)
    else $error("conversion phase length wrong");
  ready_idle_a: assert property (
    resultReady |-> !convBusy)
    else $error("result flagged while still busy");
  write_ctrl2_a: assert property (
    regWe && regAddr == `TSAG_ADDR_CTRL2 |=> s.ctrl2 == $past(regWdata))
    else $error("second control register write lost");
  aux_int_ref_a: assert property (
    convBusy && tsagDrive(s.chan) == `TSAG_DRV_OFF
    |-> adcRefSel == TSAG_REF_INT)
    else $error("non-panel channel not on internal reference");

  ratio_cov_c: cover property (!singleEnded && resultReady);
  halt_ratio_cov_c: cover property (acq.halted && !singleEnded);
  single_cov_c: cover property (singleEnded && adcConvert);
  z1_cov_c: cover property (resultReady && s.chan == `TSAG_CH_Z1);
endmodule : tsag_ctrl
`default_nettype wire

// file: test/tsag_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsag_panel_model (
  input wire logic clk,
  input wire logic haltReq,
  input wire logic polarity,
  input wire logic [3:0] plateDrv,
  input wire logic [3:0] adcMuxSel,
  input wire logic adcTrack,
  output logic acqHaltInput,
  output var logic [11:0] adcResult
);
  // Pin never floats: idle is the inactive level for the chosen polarity
  assign acqHaltInput = polarity ? haltReq : !haltReq;
  initial adcResult = 12'hA5A;
  // Track-and-hold: the level seen while tracking is frozen afterwards,
  // so the stored result proves which plates were driven at sampling.
  always @(negedge clk) begin
    if (adcTrack) begin
      adcResult <= {plateDrv, adcMuxSel, 4'h5};
    end
  end
endmodule : tsag_panel_model
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int ACQ_N = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWe = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000;
  logic convStart = 1'b0;
  logic haltReq = 1'b0;
  logic polarity = 1'b0;
  logic [15:0] regRdata;
  logic xP, xM, yP, yM, adcTrack, adcConvert, convBusy, resultReady;
  logic acqHaltInput;
  logic [11:0] adcResult;
  logic [3:0] adcMuxSel;
  logic [1:0] adcRefSel;
  logic [3:0] drv;
  int errorCnt = 0;
  int numChecks = 0;
  int cycles = 0;
  assign drv = {xP, xM, yP, yM};
  always #2.5 clk = ~clk;
  tsag_ctrl u_dut (.clk(clk), .rst_n(rst_n), .regWe(regWe),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .convStart(convStart), .adcResult(adcResult),
    .acqHaltInput(acqHaltInput), .xPlusDrv(xP), .xMinusDrv(xM),
    .yPlusDrv(yP), .yMinusDrv(yM), .adcMuxSel(adcMuxSel),
    .adcRefSel(adcRefSel), .adcTrack(adcTrack), .adcConvert(adcConvert),
    .convBusy(convBusy), .resultReady(resultReady));
  tsag_panel_model u_panel (.clk(clk), .haltReq(haltReq),
    .polarity(polarity), .plateDrv(drv), .adcMuxSel(adcMuxSel),
    .adcTrack(adcTrack), .acqHaltInput(acqHaltInput),
    .adcResult(adcResult));
  task automatic printVerdict();
    $display("checks=%0d errors=%0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : printVerdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    regWe = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWe = 1'b0;
  endtask : wr
  task automatic rdChk(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    chk(regRdata, exp);
  endtask : rdChk
  // Halt is requested over loop steps [hOn, hOff); equal values mean none
  task automatic runConv(input logic [3:0] ch, input logic se,
      input logic [3:0] dAcq, input logic [3:0] dCnv,
      input logic [1:0] rf, input int hOn, input int hOff);
    int convN;
    int relAt;
    int cnvAt;
    logic [2:0] hist;
    convN = 0;
    relAt = -1;
    cnvAt = -1;
    hist = 3'b000;
    wr(5'h01, {4'h0, se, ch, 7'h00});
    @(negedge clk);
    convStart = 1'b1;
    @(negedge clk);
    convStart = 1'b0;
    for (int i = 0; i < 400 && resultReady !== 1'b1; i++) begin
      haltReq = (i >= hOn && i < hOff);
      if (i == hOff && hOn < hOff) relAt = i;
      @(negedge clk);
      hist = {hist[1:0], haltReq};
      chk(16'(convBusy), 16'(resultReady !== 1'b1));
      if (adcTrack === 1'b1) begin
        chk(16'(drv), 16'(dAcq));
        chk(16'(adcMuxSel), 16'(ch));
        chk(16'(adcRefSel), 16'(rf));
        // Tracking shown now follows the halt level driven at the start of this step
        chk(16'(hist[0]), 16'h0000);
      end
      if (adcConvert === 1'b1) begin
        chk(16'(drv), 16'(dCnv));
        // Seen one edge after the step index, like relAt
        if (cnvAt < 0) cnvAt = i + 1;
        convN++;
      end
    end
    haltReq = 1'b0;
    chk(16'(resultReady), 16'h0001);
    chk(16'(convN), 16'h000E);
    if (relAt >= 0 && cnvAt > relAt) chk(16'(cnvAt - relAt), 16'(ACQ_N));
    rdChk({1'b1, ch}, {4'h0, dAcq, ch, 4'h5});
  endtask : runConv
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errorCnt++;
      printVerdict();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rdChk(5'h01, 16'h0000);
    rdChk(5'h02, 16'h0000);
    wr(5'h03, 16'hFFFF);
    rdChk(5'h03, 16'h0000);
    // Delay one unit of four cycles, four acquisition cycles
    wr(5'h02, 16'h0013);
    rdChk(5'h02, 16'h0013);
    runConv(4'h1, 1'b0, 4'h3, 4'h3, 2'h2, 0, 0);
    runConv(4'h0, 1'b1, 4'hC, 4'h0, 2'h0, 0, 0);
    runConv(4'hA, 1'b0, 4'h6, 4'h6, 2'h3, 6, 12);
    runConv(4'h2, 1'b0, 4'h6, 4'h6, 2'h3, 1, 4);
    wr(5'h02, 16'h001B);
    polarity = 1'b1;
    runConv(4'h3, 1'b0, 4'h0, 4'h0, 2'h0, 6, 12);
    runConv(4'h1, 1'b0, 4'h3, 4'h3, 2'h2, 12, 20);
    printVerdict();
  end
endmodule : tb
`default_nettype wire
